// >>> design/ubg_top.sv
// baud rate generator with a classic Wishbone register slave
// assumes one clock, synchronous active-low reset; the shifters consume baudTick
`timescale 1ns/1ps
`default_nettype none
`include "ubg_map.svh"

module ubg_top
   import ubg_pkg::*;
#(
   parameter int ADR_W = 8,
   parameter int PRE_W = 6
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output var  logic [31:0]      wb_dat_o,
   output var  logic             wb_ack_o,
   output var  logic             divTick,
   output var  logic             baudTick,
   output var  logic             syncMode,
   output var  logic             wideDivisor,
   output var  logic             highSpeed
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [7:0]       divLow_ff;
   logic [7:0]       divHigh_ff;
   logic [7:0]       control_ff;
   logic             ack_ff;
   logic [31:0]      rdData_ff;
   logic [31:0]      nxt_rdData;
   logic [15:0]      divCount_ff;
   logic             divTick_ff;
   logic [15:0]      tickCount_ff;
   ubg_div_t         divisor;
   ubg_mode_t        mode;
   logic [PRE_W-1:0] lastCount;
   logic             reqValid;
   logic             wrAccept;
   logic             wrLane0;
   logic             hitDivLow;
   logic             hitDivHigh;
   logic             hitControl;
   logic             hitTickCnt;
   logic             restart;
   logic             preTick;
   logic [6:0]       totalFactor;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: ack one cycle after the request, write at the edge sampling ack

   assign reqValid = wb_cyc_i & wb_stb_i;

   // a write lands at the edge where the master sees ack high
   assign wrAccept = reqValid & wb_we_i & ack_ff;
   assign wrLane0  = wrAccept & wb_sel_i[0];

   assign hitDivLow  = (wb_adr_i[ADR_W-1:2] == `UBG_OFS_DIV_LOW  >> 2);
   assign hitDivHigh = (wb_adr_i[ADR_W-1:2] == `UBG_OFS_DIV_HIGH >> 2);
   assign hitControl = (wb_adr_i[ADR_W-1:2] == `UBG_OFS_CONTROL  >> 2);
   assign hitTickCnt = (wb_adr_i[ADR_W-1:2] == `UBG_OFS_TICK_CNT >> 2);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
      end else begin
         // drops the cycle after it was given, so every access costs two edges
         ack_ff <= reqValid & ~ack_ff;
      end
   end

   always_comb begin
      nxt_rdData = 32'h0000_0000;
      case (wb_adr_i[ADR_W-1:2])
         `UBG_OFS_DIV_LOW  >> 2: nxt_rdData[7:0]  = divLow_ff;
         `UBG_OFS_DIV_HIGH >> 2: nxt_rdData[7:0]  = divHigh_ff;
         `UBG_OFS_CONTROL  >> 2: nxt_rdData[7:0]  = control_ff;
         `UBG_OFS_LIVE_CNT >> 2: nxt_rdData[15:0] = divCount_ff;
         `UBG_OFS_TICK_CNT >> 2: nxt_rdData[15:0] = tickCount_ff;
         `UBG_OFS_RATIO    >> 2: nxt_rdData[6:0]  = totalFactor;
         default:                nxt_rdData       = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdData_ff <= 32'h0000_0000;
      end else if (reqValid & ~ack_ff & ~wb_we_i) begin
         rdData_ff <= nxt_rdData;
      end else begin
         // cleared at the ack edge so data stands only beside ack
         rdData_ff <= 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdData_ff;

   ////////////////////////////////////////////////////////////////////////////
   // divisor and control registers

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         divLow_ff <= `UBG_DIV_RST;
      end else if (wrLane0 & hitDivLow) begin
         divLow_ff <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         divHigh_ff <= `UBG_DIV_RST;
      end else if (wrLane0 & hitDivHigh) begin
         divHigh_ff <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         control_ff <= `UBG_CTL_RST;
      end else if (wrLane0 & hitControl) begin
         // unused control bits stay zero
         control_ff <= wb_dat_i[7:0] & `UBG_CTL_MASK;
      end
   end

   assign syncMode    = control_ff[`UBG_CTL_SYNC];
   assign wideDivisor = control_ff[`UBG_CTL_WIDE];
   assign highSpeed   = control_ff[`UBG_CTL_HSPD];

   ////////////////////////////////////////////////////////////////////////////
   // mode decode

   // restart on the address alone, so a write with lane 0 off still restarts
   assign restart = wrAccept & (hitDivLow | hitDivHigh | hitControl);

   // high byte only joins the divisor in wide mode
   assign divisor = wideDivisor ? {divHigh_ff, divLow_ff}
                                : {8'h00, divLow_ff};

   always_comb begin
      if (syncMode) begin
         // speed bit deliberately not looked at here
         mode = wideDivisor ? UBG_SYNC16 : UBG_SYNC8;
      end else if (wideDivisor) begin
         mode = highSpeed ? UBG_ASYNC16_HIGH : UBG_ASYNC16_LOW;
      end else begin
         mode = highSpeed ? UBG_ASYNC8_HIGH : UBG_ASYNC8_LOW;
      end
   end

   always_comb begin
      case (mode)
         UBG_ASYNC8_LOW:   lastCount = PRE_W'(`UBG_LAST_64);
         UBG_ASYNC8_HIGH:  lastCount = PRE_W'(`UBG_LAST_16);
         UBG_ASYNC16_LOW:  lastCount = PRE_W'(`UBG_LAST_16);
         UBG_ASYNC16_HIGH: lastCount = PRE_W'(`UBG_LAST_4);
         UBG_SYNC8:        lastCount = PRE_W'(`UBG_LAST_4);
         UBG_SYNC16:       lastCount = PRE_W'(`UBG_LAST_4);
         default:          lastCount = PRE_W'(`UBG_LAST_64);
      endcase
   end

   assign totalFactor = 7'(lastCount) + 7'h01;

   ////////////////////////////////////////////////////////////////////////////
   // divider counter: counts 0..n, so one tick every n+1 clocks

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         divCount_ff <= `UBG_CNT_RST;
      end else if (restart) begin
         divCount_ff <= `UBG_CNT_RST;
      end else if (divCount_ff >= divisor) begin
         divCount_ff <= `UBG_CNT_RST;
      end else begin
         divCount_ff <= 16'(divCount_ff + 1'b1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         divTick_ff <= 1'b0;
      end else begin
         divTick_ff <= ~restart & (divCount_ff >= divisor);
      end
   end

   assign divTick = divTick_ff;

   ubg_prescaler #(
      .W (PRE_W)
   ) u_prescaler (
      .clk       (clk),
      .rst_n     (rst_n),
      .restart   (restart),
      .inTick    (divTick_ff),
      .lastCount (lastCount),
      .outTick   (preTick),
      .position  ()
   );

   assign baudTick = preTick;

   ////////////////////////////////////////////////////////////////////////////
   // bit-time tick counter, software clears it by writing its word

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tickCount_ff <= `UBG_CNT_RST;
      end else if (wrAccept & hitTickCnt) begin
         // a tick in the clearing cycle is kept, not lost
         tickCount_ff <= preTick ? 16'h0001 : `UBG_CNT_RST;
      end else if (preTick) begin
         tickCount_ff <= 16'(tickCount_ff + 1'b1);
      end
   end

endmodule // ubg_top

`default_nettype wire

// >>> shared/ubg_map.svh
// register map, field positions, reset values and divide ratios of the baud rate generator
// assumes a 32-bit classic Wishbone slave with byte addresses and one register per word
`ifndef UBG_MAP_SVH
`define UBG_MAP_SVH

`define UBG_OFS_DIV_LOW   8'h00
`define UBG_OFS_DIV_HIGH  8'h04
`define UBG_OFS_CONTROL   8'h08
`define UBG_OFS_LIVE_CNT  8'h10
`define UBG_OFS_TICK_CNT  8'h14
`define UBG_OFS_RATIO     8'h18

`define UBG_CTL_SYNC      0
`define UBG_CTL_WIDE      1
`define UBG_CTL_HSPD      2
`define UBG_CTL_MASK      8'h07

`define UBG_DIV_RST       8'h00
`define UBG_CTL_RST       8'h00
`define UBG_CNT_RST       16'h0000
`define UBG_PRE_RST       6'h00

// prescaler end counts, one less than the divide factor
`define UBG_LAST_64       6'h3F
`define UBG_LAST_16       6'h0F
`define UBG_LAST_4        6'h03

`endif

// >>> shared/ubg_pkg.sv
// types shared by the baud rate generator modules
// assumes ubg_map.svh carries all numeric constants
package ubg_pkg;

   typedef enum logic [2:0] {
      UBG_ASYNC8_LOW,
      UBG_ASYNC8_HIGH,
      UBG_ASYNC16_LOW,
      UBG_ASYNC16_HIGH,
      UBG_SYNC8,
      UBG_SYNC16
   } ubg_mode_t;

   typedef logic [15:0] ubg_div_t;

endpackage

// >>> design/ubg_prescaler.sv
// tick prescaler: passes one output tick for every lastCount+1 input ticks
// assumes inTick is a one-cycle pulse on clk and restart is synchronous
`timescale 1ns/1ps
`default_nettype none
`include "ubg_map.svh"

module ubg_prescaler
   import ubg_pkg::*;
#(
   parameter int W = 6
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         restart,
   input  wire logic         inTick,
   input  wire logic [W-1:0] lastCount,
   output var  logic         outTick,
   output var  logic [W-1:0] position
);

   logic [W-1:0] count_ff;
   logic         outTick_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_ff <= W'(`UBG_PRE_RST);
      end else if (restart) begin
         count_ff <= W'(`UBG_PRE_RST);
      end else if (inTick) begin
         // >= keeps a lowered end count from running all the way round
         if (count_ff >= lastCount) begin
            count_ff <= W'(`UBG_PRE_RST);
         end else begin
            count_ff <= W'(count_ff + 1'b1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         outTick_ff <= 1'b0;
      end else begin
         outTick_ff <= inTick & ~restart & (count_ff >= lastCount);
      end
   end

   assign outTick  = outTick_ff;
   assign position = count_ff;

endmodule // ubg_prescaler

`default_nettype wire

// >>> testbench/ubg_top_asserts.sv
// checker for the baud generator register slave and its tick outputs
// assumes it is bound onto ubg_top, one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module ubg_top_asserts #(
   parameter int ADR_W = 8
) (
   input wire logic             clk,
   input wire logic             rst_n,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0]       wb_sel_i,
   input wire logic [31:0]      wb_dat_i,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             wb_ack_o,
   input wire logic             divTick,
   input wire logic             baudTick,
   input wire logic             syncMode,
   input wire logic             wideDivisor,
   input wire logic             highSpeed
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   sequence sReq;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence sCtlWr;
      sReq ##0 (wb_we_i && wb_adr_i[7:2] == 6'h02 && wb_sel_i[0]);
   endsequence
   sequence sWrAck(logic [5:0] a);
      wb_ack_o && wb_cyc_i && wb_we_i && wb_adr_i[7:2] == a;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_ack_follows: assert property (sReq |=> wb_ack_o)
      else $error("no ack one cycle after request");
   a_rd_upper: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:3] == 5'h00
      |-> wb_dat_o[31:8] == 24'h000000)
      else $error("divisor byte read has upper bits set");
   a_sync_bit: assert property (sCtlWr |-> ##2 syncMode == $past(wb_dat_i[0], 2))
      else $error("mode bit not taken");
   a_wide_bit: assert property (sCtlWr |-> ##2 wideDivisor == $past(wb_dat_i[1], 2))
      else $error("wide bit not taken");
   a_speed_bit: assert property (sCtlWr |-> ##2 highSpeed == $past(wb_dat_i[2], 2))
      else $error("speed bit not taken");
   a_restart_low: assert property (sWrAck(6'h00) |=> !divTick && !baudTick)
      else $error("tick right after low byte write");
   a_restart_high: assert property (sWrAck(6'h01) |=> !divTick && !baudTick)
      else $error("tick right after high byte write");
   a_rd_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data seen outside ack");
   a_baud_div: assert property (baudTick |-> $past(divTick))
      else $error("bit tick without divider tick");
   a_low_gap: assert property (baudTick && !syncMode && !wideDivisor && !highSpeed
      |=> !baudTick [*8])
      else $error("bit ticks too close in slow mode");
endmodule // ubg_top_asserts
bind ubg_top ubg_top_asserts #(.ADR_W(ADR_W)) uChk (.clk(clk), .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .divTick(divTick), .baudTick(baudTick), .syncMode(syncMode),
   .wideDivisor(wideDivisor), .highSpeed(highSpeed));
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the baud rate generator over classic Wishbone
// assumes ubg_top with default parameters and the checker bound beside it
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hF;
   logic [31:0] dat = 32'h00000000;
   logic [31:0] rdo;
   logic [31:0] q;
   logic        ack, divTick, baudTick, syncMode, wideDivisor, highSpeed;
   int          fail_count = 0;
   int          check_count = 0;
   int          k, n1, f;
   always #12.5 clk = ~clk;
   ubg_top DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
      .divTick(divTick), .baudTick(baudTick), .syncMode(syncMode),
      .wideDivisor(wideDivisor), .highSpeed(highSpeed));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bump();
      fail_count++;
      $display("[ERR] %0t wait ran out", $time);
      give_verdict();
   endtask
   // one classic cycle; read data taken at the ack edge, then one idle cycle
   task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      i = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk);
         i++;
      end while (ack !== 1'b1 && i < 50);
      if (ack !== 1'b1) bump();
      q = rdo;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   // edges until the chosen tick is seen
   task automatic wt(input logic b, output int p);
      p = 0;
      do begin
         @(posedge clk);
         p++;
      end while ((b ? baudTick : divTick) !== 1'b1 && p < 10000);
      if (p >= 10000) bump();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      wbx(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0);
      wbx(1'b0, 8'h04, 32'h0);
      chk(q, 32'h0);
      wbx(1'b0, 8'h18, 32'h0);
      chk(q, 32'h40);
      $display("reset test done");
      wbx(1'b1, 8'h00, 32'hA5);
      wbx(1'b1, 8'h04, 32'h5A);
      wbx(1'b0, 8'h00, 32'h0);
      chk(q, 32'hA5);
      wbx(1'b0, 8'h04, 32'h0);
      chk(q, 32'h5A);
      wbx(1'b0, 8'h1C, 32'h0);
      chk(q, 32'h0);
      sel <= 4'h0;
      wbx(1'b1, 8'h00, 32'h33);
      sel <= 4'hF;
      wbx(1'b0, 8'h00, 32'h0);
      chk(q, 32'hA5);
      $display("readback test done");
      // restart shows as a late first tick when written mid-period
      wbx(1'b1, 8'h00, 32'h28);
      wt(1'b0, k);
      wt(1'b0, k);
      chk(k, 41);
      repeat (20) @(posedge clk);
      wbx(1'b1, 8'h00, 32'h28);
      wt(1'b0, k);
      chk(k, 41);
      repeat (20) @(posedge clk);
      wbx(1'b1, 8'h04, 32'h00);
      wt(1'b0, k);
      chk(k, 41);
      wbx(1'b0, 8'h10, 32'h0);
      chk(q, 32'h1);
      $display("restart test done");
      wbx(1'b1, 8'h00, 32'h02);
      wbx(1'b1, 8'h04, 32'h01);
      for (int c = 0; c < 8; c++) begin
         wbx(1'b1, 8'h08, c);
         chk(32'({highSpeed, wideDivisor, syncMode}), 32'(c));
         n1 = c[1] ? 259 : 3;
         f = c[0] ? 4 : (c[1] ? (c[2] ? 4 : 16) : (c[2] ? 16 : 64));
         wt(1'b0, k);
         wt(1'b0, k);
         chk(k, n1);
         wt(1'b1, k);
         wt(1'b1, k);
         chk(k, f * n1);
         wbx(1'b0, 8'h18, 32'h0);
         chk(q, f);
      end
      wbx(1'b1, 8'h14, 32'h0);
      wt(1'b1, k);
      wt(1'b1, k);
      wbx(1'b0, 8'h14, 32'h0);
      chk(q, 32'h2);
      $display("mode test done");
      give_verdict();
   end
endmodule // tb
`default_nettype wire
